// [rtl/rpmc_pkg.sv]
// Shared constants and types for the reset and power-mode controller.
package rpmc_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_MHZ = 50;
	// Least time that a device reset is held, in nanoseconds.
	localparam int RST_HOLD_NS = 200;
	// Rounded up to whole cycles.
	localparam int RST_HOLD_CYC = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

	// ==========================================================
	// Pin synchroniser lanes and their values under reset
	// ==========================================================
	localparam int PIN_EXT = 0;
	localparam int PIN_BROWN = 1;
	localparam int PIN_SUP = 2;
	localparam int PIN_SLOW = 3;
	localparam int PIN_XTAL = 4;
	localparam logic [4:0] PIN_RST = 5'h01;

	// ==========================================================
	// Reset cause flags
	// ==========================================================
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_BROWN = 1;
	localparam int CAUSE_EXT = 2;
	localparam int CAUSE_WD = 3;
	localparam int CAUSE_MULTI_WD = 4;
	localparam int CAUSE_SW = 5;
	localparam int CAUSE_PROT = 6;
	localparam int CAUSE_HIB = 7;
	localparam logic [7:0] CAUSE_RST = 8'h01;

	// ==========================================================
	// Watchdog counters: 0 standalone, 1..3 and 4..6 multi
	// ==========================================================
	localparam int NCNT = 7;
	localparam logic [6:0] CNT_WIDE = 7'h48;
	localparam logic [5:0] MHZ_LOW_POWER = 6'h32;
	localparam logic [5:0] MHZ_ULTRA = 6'h19;

	// One-hot sequencer states.
	typedef enum logic [3:0] {
		ST_RESET = 4'h1,
		ST_RUN = 4'h2,
		ST_DSLEEP = 4'h4,
		ST_HIB = 4'h8
	} rpmc_state_t;

	// Default clock tree setting shown to the clock block.
	typedef struct packed {
		logic from_main_osc;
		logic [5:0] mhz;
		logic others_on;
	} rpmc_clk_t;

	// Watchdog configuration from firmware.
	typedef struct packed {
		logic [6:0] en;
		logic [6:0] rst_en;
		logic [6:0][31:0] match;
		logic lf_sel;
	} rpmc_wd_cfg_t;

	// Whole state of the controller.
	typedef struct packed {
		rpmc_state_t st;
		logic [3:0] hold;
		logic [2:0][4:0] sy;
		logic [4:0] f;
		logic ultra;
		logic [7:0] cause;
		logic [6:0][31:0] cnt;
		logic [6:0] irq;
		logic prot_irq;
		logic sys_rst_n;
		logic [1:0] halt;
		logic freeze;
		logic lf_only;
		rpmc_clk_t clk;
	} rpmc_q_t;

endpackage

// [rtl/rpmc_ctrl.sv]
// Reset gathering, reset cause capture, watchdogs and power modes.
`timescale 1ns/10ps
module rpmc_ctrl (
	// Clock and power-on reset.
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Pins and supply monitors, asynchronous.
	input wire logic i_external_reset_pin_n,
	input wire logic i_brownout_reset,
	input wire logic i_supply_ok,
	input wire logic i_internal_slow_osc,
	input wire logic i_watch_crystal_osc,
	// Firmware controls.
	input wire rpmc_pkg::rpmc_wd_cfg_t i_wd_cfg,
	input wire logic [6:0] i_wd_service,
	input wire logic i_sw_reset,
	input wire logic i_prot_fault,
	input wire logic i_prot_rst_en,
	input wire logic i_prot_irq_clr,
	input wire logic [7:0] i_cause_clr,
	input wire logic i_ultra_low_power_sel,
	input wire logic [1:0] i_cpu_deep_sleep,
	input wire logic i_hib_req,
	input wire logic i_wake,
	// Status and control outputs.
	output logic o_sys_rst_n,
	output logic [7:0] o_cause,
	output logic [6:0] o_wd_irq,
	output logic o_prot_irq,
	output logic [1:0] o_cpu_halt,
	output logic o_io_freeze,
	output logic o_lf_only,
	output logic o_system_ultra_low_power_mode,
	output rpmc_pkg::rpmc_clk_t o_clk_cfg
);
	import rpmc_pkg::*;

	// ==========================================================
	// Reset release
	// ==========================================================
	logic [1:0] rsync; // Release synchroniser for the power-on reset.
	logic rst_b; // Synchronously released power-on reset.
	rpmc_q_t q; // Registered state.
	rpmc_q_t n; // Next state.
	logic [4:0] rise; // Filtered rising edges of the pins.
	logic [7:0] src; // Device reset sources seen this cycle.
	logic lf_tick; // Selected low-frequency clock edge.

	// Assertion is immediate, release waits two edges.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rsync <= 2'h0;
		end else begin
			rsync <= {rsync[0], 1'b1};
		end
	end
	assign rst_b = rsync[1];

	// The hold counter is four bits wide; the checks rely on eight.
	if (RST_HOLD_CYC > 15 || RST_HOLD_CYC < 8) begin : g_chk
		$error("reset hold count out of range");
	end

	// Count step; 16-bit counters wrap at 16 bits.
	function automatic logic [31:0] cnt_next(input logic [31:0] c,
		input logic wide);
		cnt_next = wide ? c + 32'h1 : {16'h0, c[15:0] + 16'h1};
	endfunction

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		n = q;
		src = 8'h0;
		// Three flops; a change counts once stages two and three agree.
		n.sy = {q.sy[1:0], i_watch_crystal_osc, i_internal_slow_osc,
			i_supply_ok, i_brownout_reset, i_external_reset_pin_n};
		n.f = (q.sy[1] & q.sy[2]) | (q.f & (q.sy[1] | q.sy[2]));
		rise = n.f & ~q.f;
		// Multi watchdogs may run from either slow source.
		lf_tick = i_wd_cfg.lf_sel ? rise[PIN_XTAL] : rise[PIN_SLOW];
		// Watchdog counters run while out of reset.
		for (int k = 0; k < NCNT; k++) begin
			if (i_wd_service[k]) begin
				n.cnt[k] = 32'h0;
				n.irq[k] = 1'b0;
			end
			// The standalone one also runs in hibernate.
			// Counters stand still while the device is held in reset.
			if (i_wd_cfg.en[k] && q.sys_rst_n && (k == 0 ? rise[PIN_SLOW]
				: (lf_tick && q.st != ST_HIB))) begin
				n.cnt[k] = cnt_next(q.cnt[k], CNT_WIDE[k]);
				if (q.cnt[k] == i_wd_cfg.match[k]) begin
					// A match sets the flag even when serviced now.
					n.irq[k] = 1'b1;
					// Second match unserviced: only 16-bit ones reset.
					if (q.irq[k] && i_wd_cfg.rst_en[k] && !CNT_WIDE[k]) begin
						src[k == 0 ? CAUSE_WD : CAUSE_MULTI_WD] = 1'b1;
					end
				end
			end
		end
		// Protection fault goes to reset or to a sticky interrupt.
		n.prot_irq = q.prot_irq & ~i_prot_irq_clr;
		if (i_prot_fault && q.sys_rst_n) begin
			if (i_prot_rst_en) begin
				src[CAUSE_PROT] = 1'b1;
			end else begin
				n.prot_irq = 1'b1;
			end
		end
		// Level sources keep restarting the hold while they stand.
		// The hold therefore times from the release of the source.
		src[CAUSE_BROWN] = q.f[PIN_BROWN];
		src[CAUSE_EXT] = ~q.f[PIN_EXT];
		src[CAUSE_SW] = i_sw_reset;
		src[CAUSE_HIB] = (q.st == ST_HIB) && (i_wake || n.irq[0]);
		// Sticky flags; a new cause wins over its clear.
		n.cause = (q.cause & ~i_cause_clr) | src;
		// A CPU in deep sleep is halted and asks for deep sleep.
		n.halt = i_cpu_deep_sleep & {2{q.sys_rst_n}};
		case (q.st)
			ST_RESET: begin
				// Leave only after the hold and once the supply is good.
				if (q.hold != RST_HOLD_CYC[3:0] - 4'h1) begin
					n.hold = q.hold + 4'h1;
				end else if (q.f[PIN_SUP] && src == 8'h0) begin
					n.st = ST_RUN;
					n.sys_rst_n = 1'b1;
					n.ultra = i_ultra_low_power_sel;
				end
			end
			ST_RUN: begin
				// Mode changes wait for the supply; deep sleep wins over hibernate.
				if (q.f[PIN_SUP]) begin
					n.ultra = i_ultra_low_power_sel;
					if (&q.halt) begin
						n.st = ST_DSLEEP;
						n.lf_only = 1'b1;
					end else if (i_hib_req) begin
						n.st = ST_HIB;
						n.freeze = 1'b1;
					end
				end
			end
			ST_DSLEEP: begin
				// Any wakeup source, including a counter match.
				if (i_wake || (|n.irq)) begin
					n.st = ST_RUN;
					n.lf_only = 1'b0;
				end
			end
			ST_HIB: begin
				// Only the standalone counter runs here; wakeup leaves only through reset.
				n.freeze = 1'b1;
			end
			default: begin
				n.st = ST_RESET;
			end
		endcase
		// Any source throws the device into a known reset state.
		if (src != 8'h0) begin
			n.st = ST_RESET;
			n.hold = 4'h0;
			n.sys_rst_n = 1'b0;
			n.cnt = '0;
			n.irq = 7'h0;
			n.prot_irq = 1'b0;
			n.freeze = 1'b0;
			n.lf_only = 1'b0;
			n.halt = 2'h0;
		end
		// Main clock from the main oscillator through the locked loop.
		// The rate follows the mode in the same edge, so a clock
		// block never sees the fast rate in the slow mode.
		n.clk.from_main_osc = 1'b1;
		n.clk.mhz = n.ultra ? MHZ_ULTRA : MHZ_LOW_POWER;
		n.clk.others_on = 1'b0;
	end

	// ==========================================================
	// State register
	// ==========================================================
	// Power-on clears the state; of the cause flags only the power-on one is left set.
	always_ff @(posedge i_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			q.st <= ST_RESET;
			q.sy <= {3{PIN_RST}};
			q.f <= PIN_RST;
			q.cause <= CAUSE_RST;
			q.clk.from_main_osc <= 1'b1;
			q.clk.mhz <= MHZ_LOW_POWER;
		end else begin
			q <= n;
		end
	end

	// Outputs straight from flops.
	assign o_sys_rst_n = q.sys_rst_n;
	assign o_cause = q.cause;
	assign o_wd_irq = q.irq;
	assign o_prot_irq = q.prot_irq;
	assign o_cpu_halt = q.halt;
	assign o_io_freeze = q.freeze;
	assign o_lf_only = q.lf_only;
	assign o_system_ultra_low_power_mode = q.ultra;
	assign o_clk_cfg = q.clk;

	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_b);

	AST_POR_HOLD: assert property (q.st == ST_RESET && !q.f[PIN_SUP]
		|=> !q.sys_rst_n) else $error("left reset without supply");
	AST_BROWN: assert property (q.f[PIN_BROWN]
		|=> !q.sys_rst_n && q.cause[CAUSE_BROWN]) else $error("brown-out lost");
	AST_EXT_PIN: assert property (!q.f[PIN_EXT]
		|=> !q.sys_rst_n && q.cause[CAUSE_EXT]) else $error("pin reset lost");
	AST_WATCHDOG: assert property (src[CAUSE_WD]
		|=> q.cause[CAUSE_WD] && q.cnt[0] == 32'h0) else $error("wd reset");
	AST_SW: assert property (i_sw_reset |=> !q.sys_rst_n
		##1 !q.sys_rst_n) else $error("software reset too short");
	AST_PROT: assert property (i_prot_fault && !i_prot_rst_en
		&& q.sys_rst_n && src == 8'h0 |=> q.prot_irq)
		else $error("fault irq lost");
	AST_HIB: assert property (q.st == ST_HIB && i_wake
		|=> q.st == ST_RESET && q.cause[CAUSE_HIB]) else $error("hib wake");
	AST_HOLD: assert property ($fell(q.sys_rst_n)
		|-> !q.sys_rst_n [*8]) else $error("reset pulse too short");
	AST_KEEP: assert property (i_cause_clr == 8'h0
		|=> (q.cause & $past(q.cause)) == $past(q.cause))
		else $error("cause flag dropped");
	AST_MATCH: assert property (i_wd_cfg.en[3] && q.sys_rst_n
		&& lf_tick && q.st == ST_RUN && src == 8'h0
		&& q.cnt[3] == i_wd_cfg.match[3] |=> q.irq[3])
		else $error("match irq lost");
	AST_MC_HIB: assert property (q.st == ST_HIB ##1 q.st == ST_HIB
		|-> $stable(q.cnt[1])) else $error("multi wdt ran in hibernate");
	AST_DS: assert property ($rose(q.st == ST_DSLEEP)
		|-> $past(&q.halt) && q.lf_only) else $error("early deep sleep");
	AST_FRZ: assert property (q.st == ST_HIB |-> q.freeze)
		else $error("hibernate not frozen");
	AST_CLK: assert property (q.sys_rst_n |-> !q.clk.others_on
		&& q.clk.mhz == (q.ultra ? MHZ_ULTRA : MHZ_LOW_POWER))
		else $error("clock cfg");
	AST_SUP: assert property (q.st == ST_RUN && !q.f[PIN_SUP]
		|=> q.st != ST_DSLEEP && q.st != ST_HIB) else $error("mode w/o supply");
	// A fault set to reset must throw the device into reset.
	AST_PROT_RST: assert property (i_prot_fault && i_prot_rst_en
		&& q.sys_rst_n |=> !q.sys_rst_n && q.cause[CAUSE_PROT])
		else $error("fault reset lost");
	// A sleeping CPU is shown halted one edge later while running.
	AST_HALT: assert property (q.sys_rst_n && src == 8'h0
		&& i_cpu_deep_sleep[0] |=> q.halt[0]) else $error("cpu not halted");
	// A multi counter reset lands in its own cause flag.
	AST_MC_RST: assert property (src[CAUSE_MULTI_WD]
		|=> !q.sys_rst_n && q.cause[CAUSE_MULTI_WD])
		else $error("multi wd reset lost");
	// A standing standalone flag in hibernate wakes through reset.
	AST_HIB_WD: assert property (q.st == ST_HIB && q.irq[0]
		&& !i_wd_service[0] |=> q.st == ST_RESET)
		else $error("hibernate wd wake lost");
	// A wakeup in deep sleep brings the fast clocks back.
	AST_DS_EXIT: assert property (q.st == ST_DSLEEP && i_wake
		&& src == 8'h0 |=> q.st == ST_RUN && !q.lf_only)
		else $error("deep sleep exit lost");

	// ==========================================================
	// Cover points
	// ==========================================================
	// The main scenarios that the bench is meant to reach.
	COV_DS: cover property (q.st == ST_DSLEEP ##[1:20] q.st == ST_RUN);
	COV_HIB: cover property (q.st == ST_HIB ##1 q.cause[CAUSE_HIB]);
	COV_WATCHDOG: cover property (src[CAUSE_WD]);
	COV_MC_RST: cover property (src[CAUSE_MULTI_WD]);
	COV_PROT: cover property (q.prot_irq);

endmodule

// [verification/rpmc_far_end.sv]
// Far-side model: reset pin driver and the two slow oscillators.
`timescale 1ns/10ps
module rpmc_far_end (
	// Clock and commands from the bench.
	input wire logic i_clk,
	input wire logic i_pin_low,
	// Lines towards the controller.
	output logic o_pin_n,
	output logic o_slow_osc,
	output logic o_xtal_osc
);
	// Divider; oscillators are sped up so that counts fit a short run.
	logic [3:0] div = 4'h0;
	// Free-running count, the slow clocks are its upper bits.
	always @(posedge i_clk) begin
		div <= div + 4'h1;
	end
	// The driver pulls the pin low to ask for a reset.
	assign o_pin_n = !i_pin_low;
	assign o_slow_osc = div[2];
	assign o_xtal_osc = div[3];
endmodule

// [verification/testbench.sv]
// Self-checking bench for the reset and power-mode controller.
`timescale 1ns/10ps
module testbench;
	import rpmc_pkg::*;
	// Drives, all valued at time zero.
	logic clk = 1'b0, rst_b = 1'b0, pin_low = 1'b0, brown = 1'b0;
	logic sup = 1'b1;
	logic sw = 1'b0, pf = 1'b0, pf_en = 1'b0, pf_clr = 1'b0, ultra = 1'b0;
	logic hib = 1'b0, wake = 1'b0;
	logic [7:0] cclr = 8'h00;
	logic [6:0] svc = 7'h00;
	logic [1:0] cds = 2'h0;
	rpmc_wd_cfg_t cfg = '0;
	// Observed outputs.
	logic rst_n, pirq, frz, lfo, ultra_m, pin_n, slow_clk, xtal_clk;
	logic [7:0] cause;
	logic [6:0] wdi;
	logic [1:0] halt;
	rpmc_clk_t ccfg;
	int n_fail = 0;
	int tests_run = 0;

	always #10 clk = ~clk;

	rpmc_far_end far_u (.i_clk(clk), .i_pin_low(pin_low), .o_pin_n(pin_n),
		.o_slow_osc(slow_clk), .o_xtal_osc(xtal_clk));
	rpmc_ctrl dut_u (.i_clk(clk), .i_rst_b(rst_b),
		.i_external_reset_pin_n(pin_n), .i_brownout_reset(brown),
		.i_supply_ok(sup), .i_internal_slow_osc(slow_clk),
		.i_watch_crystal_osc(xtal_clk), .i_wd_cfg(cfg), .i_wd_service(svc),
		.i_sw_reset(sw), .i_prot_fault(pf), .i_prot_rst_en(pf_en),
		.i_prot_irq_clr(pf_clr), .i_cause_clr(cclr),
		.i_ultra_low_power_sel(ultra),
		.i_cpu_deep_sleep(cds), .i_hib_req(hib), .i_wake(wake),
		.o_sys_rst_n(rst_n), .o_cause(cause), .o_wd_irq(wdi),
		.o_prot_irq(pirq), .o_cpu_halt(halt), .o_io_freeze(frz),
		.o_lf_only(lfo), .o_system_ultra_low_power_mode(ultra_m),
		.o_clk_cfg(ccfg));

	// Every comparison goes through here and is counted.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Bounded wait for the device reset to reach a level.
	task automatic wait_rst(input logic lvl);
		for (int i = 0; i < 40 && rst_n !== lvl; i++) @(negedge clk);
		chk(rst_n, lvl);
	endtask

	// A device reset must stand its full hold, then end by itself.
	task automatic ride_rst;
		int n = 0;
		while (rst_n === 1'b0 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk(n >= RST_HOLD_CYC - 1 && rst_n === 1'b1, 1);
	endtask

	// Flags are cleared first so each source proves its own bit.
	task automatic clr_cause;
		cclr = 8'hFF;
		@(negedge clk);
		cclr = 8'h00;
		chk(cause, 8'h00);
	endtask

	task automatic t_boot;
		chk(cause, CAUSE_RST);
		chk(ccfg, {1'b1, 6'h32, 1'b0});
		wait_rst(1'b1);
		chk(cause, 8'h01);
	endtask

	task automatic t_sw;
		clr_cause();
		sw = 1'b1;
		@(negedge clk);
		sw = 1'b0;
		chk(rst_n, 1'b0);
		chk(cause, 8'h20);
		ride_rst();
	endtask

	// Pin, then brown-out with the supply lost while in reset.
	task automatic t_pin_brown;
		clr_cause();
		pin_low = 1'b1;
		wait_rst(1'b0);
		repeat (20) @(negedge clk);
		chk({rst_n, cause}, 9'h004);
		pin_low = 1'b0;
		ride_rst();
		clr_cause();
		brown = 1'b1;
		wait_rst(1'b0);
		chk(cause[CAUSE_BROWN], 1'b1);
		sup = 1'b0;
		brown = 1'b0;
		repeat (30) @(negedge clk);
		chk(rst_n, 1'b0);
		sup = 1'b1;
		wait_rst(1'b1);
	endtask

	task automatic t_prot;
		pf = 1'b1;
		@(negedge clk);
		pf = 1'b0;
		chk({rst_n, pirq}, 2'h3);
		pf_clr = 1'b1;
		@(negedge clk);
		pf_clr = 1'b0;
		chk(pirq, 1'b0);
		clr_cause();
		pf_en = 1'b1;
		pf = 1'b1;
		@(negedge clk);
		pf = 1'b0;
		pf_en = 1'b0;
		chk({rst_n, cause}, 9'h040);
		ride_rst();
	endtask

	// All seven counters on match 1, multi ones on the crystal.
	task automatic t_wdt;
		for (int k = 0; k < NCNT; k++) cfg.match[k] = 32'h1;
		cfg.lf_sel = 1'b1;
		cfg.en = 7'h7F;
		for (int i = 0; i < 300 && wdi !== 7'h7F; i++) @(negedge clk);
		chk(wdi, 7'h7F);
		svc = 7'h7F;
		@(negedge clk);
		svc = 7'h00;
		cfg.en = 7'h00;
		chk(wdi, 7'h00);
	endtask

	task automatic t_modes;
		cds = 2'h1;
		repeat (5) @(negedge clk);
		chk({halt, lfo}, 3'h2);
		cds = 2'h3;
		repeat (3) @(negedge clk);
		chk(lfo, 1'b1);
		wake = 1'b1;
		cds = 2'h0;
		@(negedge clk);
		wake = 1'b0;
		@(negedge clk);
		chk(lfo, 1'b0);
		ultra = 1'b1;
		repeat (2) @(negedge clk);
		chk({ultra_m, ccfg.mhz}, {1'b1, MHZ_ULTRA});
		ultra = 1'b0;
		repeat (2) @(negedge clk);
		chk(ccfg.mhz, 6'h32);
		clr_cause();
		hib = 1'b1;
		repeat (3) @(negedge clk);
		hib = 1'b0;
		repeat (5) @(negedge clk);
		chk(frz, 1'b1);
		wake = 1'b1;
		@(negedge clk);
		wake = 1'b0;
		chk({rst_n, cause}, 9'h080);
		ride_rst();
		chk(frz, 1'b0);
	endtask

	// Second unserviced match of a 16-bit counter resets the device.
	task automatic t_wd_rst(input int k, input logic [7:0] exp);
		clr_cause();
		svc[k] = 1'b1;
		@(negedge clk);
		svc[k] = 1'b0;
		cfg.match[k] = 32'h1;
		cfg.rst_en[k] = 1'b1;
		cfg.en[k] = 1'b1;
		for (int i = 0; i < 100 && wdi[k] !== 1'b1; i++) @(negedge clk);
		chk(wdi[k], 1'b1);
		cfg.match[k] = 32'h3;
		for (int i = 0; i < 100 && rst_n !== 1'b0; i++) @(negedge clk);
		chk({rst_n, cause}, {1'b0, exp});
		cfg.en[k] = 1'b0;
		cfg.rst_en[k] = 1'b0;
		ride_rst();
	endtask

	// A power-on reset in mid-run clears every flag but its own.
	task automatic t_por;
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		chk({rst_n, cause}, 9'h001);
		rst_b = 1'b1;
		wait_rst(1'b1);
	endtask

	task automatic report_and_stop;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Main sequence; reset held for eight cycles first.
	initial begin
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		t_boot();
		t_sw();
		t_pin_brown();
		t_prot();
		t_wdt();
		t_wd_rst(0, 8'h08);
		t_wd_rst(1, 8'h10);
		t_modes();
		t_por();
		report_and_stop();
	end

	// Whole run is a few hundred cycles; the limit of ten thousand cycles leaves ample margin.
	initial begin
		#200000;
		n_fail++;
		report_and_stop();
	end
endmodule
